/* File: hdl/tsr_regs.v */
// Result, status and control registers with the conversion sequencer.
// Assumes a serial engine on sys_clk_i presents pointer, data and read strobes,
// and an analog front end presents its result while conv_busy_o is high.
`timescale 1ns/100ps
`default_nettype none
`include "tsr_consts.vh"

module tsr_regs #(
  parameter [31:0] CONV_CYC = `TSR_CONV_TIME_US * `TSR_CLK_MHZ,
  parameter [31:0] TOP_PERIOD_CYC = `TSR_TOP_RATE_PERIOD_US * `TSR_CLK_MHZ
) (
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // Host register port
  input wire ptr_wr_i,
  input wire [7:0] ptr_i,
  input wire data_wr_i,
  input wire [7:0] wdata_i,
  input wire rd_req_i,
  input wire rd_cont_i,
  output wire [7:0] rd_data_o,
  output wire rd_valid_o,
  // Analog front end
  input wire [15:0] conv_result_i,
  output wire conv_busy_o,
  output wire [1:0] conv_chan_o,
  output wire conv_rc_o,
  output wire ext_range_o
);

  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;
  localparam [1:0] CH_NONE = 2'd3;

  reg [7:0] ptr_r;
  reg [7:0] cfg1_r;
  reg [7:0] cfg2_r;
  reg [7:0] rate_r;
  reg [15:0] res_r [0:2];
  reg [7:0] shadow_lo_r;
  reg [1:0] shadow_ch_r;
  reg shadow_ok_r;
  reg [7:0] rd_data_r;
  reg rd_valid_r;
  reg st_r;
  reg [1:0] ch_r;
  reg [31:0] tmr_r;
  reg [31:0] per_cnt_r;
  integer i;

  wire halt_conversions = cfg1_r[`TSR_HALT_BIT];
  wire series_res_correct_en = cfg2_r[`TSR_RC_BIT];
  wire local_channel_en = cfg2_r[`TSR_LOCAL_EN_BIT];
  wire ext1_channel_en = cfg2_r[`TSR_EXT1_EN_BIT];
  wire ext2_channel_en = cfg2_r[`TSR_EXT2_EN_BIT];
  wire [2:0] ch_en = {ext2_channel_en, ext1_channel_en, local_channel_en};
  wire trigger_wr = data_wr_i && (ptr_r == `TSR_ADDR_TRIGGER);
  wire conv_done = (st_r == ST_CONV) && (tmr_r == 32'd0);
  wire [2:0] rate_shift = 3'd7 - rate_r[2:0];
  wire [31:0] period_cyc = TOP_PERIOD_CYC << rate_shift;
  wire start_now = (!halt_conversions && per_cnt_r == 32'd0) || trigger_wr;
  wire [1:0] first_ch = next_ch(2'd0, ch_en);
  wire [1:0] follow_ch = next_ch(ch_r + 2'd1, ch_en);

  // First enabled channel at or after a position
  function [1:0] next_ch;
    input [1:0] from;
    input [2:0] en;
    integer k;
    begin
      next_ch = CH_NONE;
      for (k = 2; k >= 0; k = k - 1) begin
        if (k >= from && en[k]) begin
          next_ch = k[1:0];
        end
      end
    end
  endfunction

  // Cycles spent converting one channel
  function [31:0] conv_len;
    input [1:0] c;
    input rc;
    begin
      if (c != 2'd0 && !rc) begin
        conv_len = CONV_CYC >> 1;
      end else begin
        conv_len = CONV_CYC;
      end
    end
  endfunction

  // Pointer and writable configuration
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      ptr_r <= `TSR_PTR_RST;
      cfg1_r <= `TSR_CFG1_RST;
      cfg2_r <= `TSR_CFG2_RST;
      rate_r <= `TSR_RATE_RST;
    end else begin
      if (ptr_wr_i) begin
        ptr_r <= ptr_i;
      end
      if (data_wr_i) begin
        case (ptr_r)
          `TSR_ADDR_CFG1: begin
            cfg1_r <= wdata_i & `TSR_CFG1_MASK;
          end
          `TSR_ADDR_CFG2: begin
            cfg2_r <= wdata_i & `TSR_CFG2_MASK;
          end
          `TSR_ADDR_RATE: begin
            rate_r <= wdata_i & `TSR_RATE_MASK;
          end
          default: begin
            // Read-only and trigger addresses store nothing
            ptr_r <= ptr_r;
          end
        endcase
      end
    end
  end

  // Conversion sequencer
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_r <= ST_IDLE;
      ch_r <= 2'd0;
      tmr_r <= 32'd0;
      per_cnt_r <= 32'd0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (start_now) begin
            per_cnt_r <= period_cyc - 32'd1;
            if (first_ch != CH_NONE) begin
              st_r <= ST_CONV;
              ch_r <= first_ch;
              tmr_r <= conv_len(first_ch, series_res_correct_en) - 32'd1;
            end
          end else if (halt_conversions) begin
            // Release of halt starts at once
            per_cnt_r <= 32'd0;
          end else if (per_cnt_r != 32'd0) begin
            per_cnt_r <= per_cnt_r - 32'd1;
          end
        end
        ST_CONV: begin
          // Trigger writes are not looked at here
          if (per_cnt_r != 32'd0) begin
            per_cnt_r <= per_cnt_r - 32'd1;
          end
          if (tmr_r == 32'd0) begin
            if (follow_ch == CH_NONE) begin
              st_r <= ST_IDLE;
            end else begin
              ch_r <= follow_ch;
              tmr_r <= conv_len(follow_ch, series_res_correct_en) - 32'd1;
            end
          end else begin
            tmr_r <= tmr_r - 32'd1;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Result capture at end of each channel
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      for (i = 0; i < 3; i = i + 1) begin
        res_r[i] <= `TSR_RESULT_RST;
      end
    end else if (conv_done) begin
      res_r[ch_r] <= conv_result_i;
    end
  end

  // Read path with coherent low byte
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      rd_data_r <= 8'h00;
      rd_valid_r <= 1'b0;
      shadow_lo_r <= 8'h00;
      shadow_ch_r <= 2'd0;
      shadow_ok_r <= 1'b0;
    end else begin
      rd_valid_r <= rd_req_i;
      if (rd_req_i) begin
        case (ptr_r)
          `TSR_ADDR_LOCAL_HI, `TSR_ADDR_EXT1_HI, `TSR_ADDR_EXT2_HI: begin
            if (rd_cont_i && shadow_ok_r && shadow_ch_r == ptr_r[1:0]) begin
              rd_data_r <= shadow_lo_r;
              shadow_ok_r <= 1'b0;
            end else begin
              rd_data_r <= res_r[ptr_r[1:0]][15:8];
              shadow_lo_r <= res_r[ptr_r[1:0]][7:0];
              shadow_ch_r <= ptr_r[1:0];
              shadow_ok_r <= 1'b1;
            end
          end
          `TSR_ADDR_LOCAL_LO, `TSR_ADDR_EXT1_LO, `TSR_ADDR_EXT2_LO: begin
            if (shadow_ok_r && shadow_ch_r == ptr_r[1:0]) begin
              rd_data_r <= shadow_lo_r;
            end else begin
              rd_data_r <= res_r[ptr_r[1:0]][7:0];
            end
            shadow_ok_r <= 1'b0;
          end
          `TSR_ADDR_STATE: begin
            rd_data_r <= {st_r, 7'h00};
            shadow_ok_r <= 1'b0;
          end
          `TSR_ADDR_CFG1: begin
            rd_data_r <= cfg1_r;
            shadow_ok_r <= 1'b0;
          end
          `TSR_ADDR_CFG2: begin
            rd_data_r <= cfg2_r;
            shadow_ok_r <= 1'b0;
          end
          `TSR_ADDR_RATE: begin
            rd_data_r <= rate_r;
            shadow_ok_r <= 1'b0;
          end
          default: begin
            rd_data_r <= 8'h00;
            shadow_ok_r <= 1'b0;
          end
        endcase
      end
    end
  end

  assign rd_data_o = rd_data_r;
  assign rd_valid_o = rd_valid_r;
  assign conv_busy_o = st_r;
  assign conv_chan_o = ch_r;
  assign conv_rc_o = cfg2_r[`TSR_RC_BIT];
  assign ext_range_o = cfg1_r[`TSR_RANGE_BIT];

endmodule

`default_nettype wire

/* File: hdl/tsr_consts.vh */
// Constants for the temperature result, status and control register block.
// Assumes a 100 MHz system clock and a byte-wide register port from the serial engine.
// Functional notes
// - High result bytes at pointers 00h, 01h, 02h
// - Low result bytes at pointers 10h, 11h, 12h
// - Results read-only, refreshed when conversion finishes
// - Low read after high gives same conversion
// - Two-byte read returns high then low byte
// - Results read zero after reset until converted
// - Status 08h shows busy in bit 7 only
// - First conversion starts promptly after reset
// - Halt clear converts continuously at chosen rate
// - Halt set finishes sequence, then stops converting
// - Configuration 1 bit 2 selects extended range
// - Trigger write in halt runs one sequence
// - Trigger write during a sequence is ignored
// - Trigger in idle gap starts sequence immediately
// - Configuration 2 bit 2 enables resistance correction
// - Correction off halves external conversion time
// - Configuration 2 bits 3..5 enable channels
// - Order local, external 1, external 2, then idle
// - Rate register sets period from one sequence start to the next
// - Rate codes 0..7 give 1/16 to 8 per second
// - Pointer loaded by host write, reset zero; a same-cycle data write to an address other than 09h..0Bh cancels the load
`ifndef TSR_CONSTS_VH
`define TSR_CONSTS_VH

// Pointer addresses
`define TSR_ADDR_LOCAL_HI 8'h00
`define TSR_ADDR_EXT1_HI 8'h01
`define TSR_ADDR_EXT2_HI 8'h02
`define TSR_ADDR_STATE 8'h08
`define TSR_ADDR_CFG1 8'h09
`define TSR_ADDR_CFG2 8'h0a
`define TSR_ADDR_RATE 8'h0b
`define TSR_ADDR_TRIGGER 8'h0f
`define TSR_ADDR_LOCAL_LO 8'h10
`define TSR_ADDR_EXT1_LO 8'h11
`define TSR_ADDR_EXT2_LO 8'h12

// Field positions
`define TSR_BUSY_BIT 7
`define TSR_HALT_BIT 6
`define TSR_RANGE_BIT 2
`define TSR_RC_BIT 2
`define TSR_LOCAL_EN_BIT 3
`define TSR_EXT1_EN_BIT 4
`define TSR_EXT2_EN_BIT 5

// Writable bit masks
`define TSR_CFG1_MASK 8'h44
`define TSR_CFG2_MASK 8'h3c
`define TSR_RATE_MASK 8'h07

// Reset values
`define TSR_PTR_RST 8'h00
`define TSR_CFG1_RST 8'h00
`define TSR_CFG2_RST 8'h1c
`define TSR_RATE_RST 8'h07
`define TSR_RESULT_RST 16'h0000

// Timing
`define TSR_CLK_MHZ 100
`define TSR_CONV_TIME_US 10000
`define TSR_TOP_RATE_PERIOD_US 125000

`endif

/* File: dv/tsr_props.sv */
// Port checker for the register block.
// Bound to every tsr_regs instance.
`timescale 1ns/100ps
`default_nettype none
module tsr_props (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Host port
  input wire logic ptr_wr_i,
  input wire logic [7:0] ptr_i,
  input wire logic data_wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic rd_req_i,
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  // Converter
  input wire logic conv_busy_o,
  input wire logic [1:0] conv_chan_o,
  input wire logic conv_rc_o,
  input wire logic ext_range_o
);
  reg [7:0] ptr_r;
  reg halt_r;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Shadow of pointer and halt
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      ptr_r <= 8'h00;
      halt_r <= 1'b0;
    end else begin
      if (ptr_wr_i)
        ptr_r <= ptr_i;
      if (data_wr_i && ptr_r == 8'h09)
        halt_r <= wdata_i[6];
    end
  end
  rd_answer_a: assert property (rd_valid_o == $past(rd_req_i))
    else $error("read answer timing wrong");
  boot_busy_a: assert property ($fell(rst_i) |=> conv_busy_o)
    else $error("no conversion after reset");
  state_read_a: assert property (rd_req_i && ptr_r == 8'h08 |=>
    rd_data_o == {$past(conv_busy_o), 7'h00}) else $error("status byte wrong");
  halt_idle_a: assert property (halt_r && !conv_busy_o && !data_wr_i |=> !conv_busy_o)
    else $error("conversion while halted");
  trig_start_a: assert property (data_wr_i && ptr_r == 8'h0f && !conv_busy_o |=> conv_busy_o)
    else $error("trigger did not start");
  range_follow_a: assert property (data_wr_i && ptr_r == 8'h09 |-> ##2
    ext_range_o == $past(wdata_i[2], 2)) else $error("range output wrong");
  rc_follow_a: assert property (data_wr_i && ptr_r == 8'h0a |-> ##2
    conv_rc_o == $past(wdata_i[2], 2)) else $error("correction output wrong");
  chan_order_a: assert property (conv_busy_o && $past(conv_busy_o) &&
    conv_chan_o != $past(conv_chan_o) |-> conv_chan_o > $past(conv_chan_o))
    else $error("channel order wrong");
  zero_read_a: assert property (rd_req_i && ptr_r == 8'h0f |=> rd_data_o == 8'h00)
    else $error("trigger reads nonzero");
endmodule
bind tsr_regs tsr_props u_props (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .ptr_wr_i(ptr_wr_i), .ptr_i(ptr_i), .data_wr_i(data_wr_i), .wdata_i(wdata_i),
  .rd_req_i(rd_req_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
  .conv_busy_o(conv_busy_o), .conv_chan_o(conv_chan_o), .conv_rc_o(conv_rc_o),
  .ext_range_o(ext_range_o));
`default_nettype wire

/* File: dv/tsr_fe_model.sv */
// Front-end model: converter result per channel.
// Follows the block's busy and channel outputs.
`timescale 1ns/100ps
`default_nettype none
module tsr_fe_model (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Sequencer view
  input wire logic conv_busy_o,
  input wire logic [1:0] conv_chan_o,
  // Results
  output wire logic [15:0] conv_result_o,
  output var logic [5:0] seq_o
);
  reg busy_r;
  wire [15:0] pat;
  assign pat = {seq_o, conv_chan_o, seq_o, ~conv_chan_o};
  // Garbage while nothing converts
  assign conv_result_o = conv_busy_o ? pat : ~pat;
  always @(posedge sys_clk_i) begin
    busy_r <= conv_busy_o;
    if (rst_i)
      seq_o <= 6'h00;
    else if (conv_busy_o && !busy_r)
      seq_o <= seq_o + 6'h01;
  end
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench for the register block.
// Short conversion and period counts.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  reg sys_clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg ptr_wr_i = 1'b0;
  reg [7:0] ptr_i = 8'h00;
  reg data_wr_i = 1'b0;
  reg [7:0] wdata_i = 8'h00;
  reg rd_req_i = 1'b0;
  reg rd_cont_i = 1'b0;
  wire [15:0] conv_result_i;
  wire [7:0] rd_data_o;
  wire rd_valid_o, conv_busy_o, conv_rc_o, ext_range_o;
  wire [1:0] conv_chan_o;
  wire [5:0] seq;
  integer bad_count = 0;
  integer compares = 0;
  reg [7:0] lfsr = 8'h27;
  reg [5:0] s;
  reg [7:0] expq[$];
  tsr_regs #(.CONV_CYC(20), .TOP_PERIOD_CYC(100)) dut (.sys_clk_i(sys_clk_i),
    .rst_i(rst_i), .ptr_wr_i(ptr_wr_i), .ptr_i(ptr_i), .data_wr_i(data_wr_i),
    .wdata_i(wdata_i), .rd_req_i(rd_req_i), .rd_cont_i(rd_cont_i),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .conv_result_i(conv_result_i),
    .conv_busy_o(conv_busy_o), .conv_chan_o(conv_chan_o), .conv_rc_o(conv_rc_o),
    .ext_range_o(ext_range_o));
  tsr_fe_model fe (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .conv_busy_o(conv_busy_o),
    .conv_chan_o(conv_chan_o), .conv_result_o(conv_result_i), .seq_o(seq));
  always #5 sys_clk_i = ~sys_clk_i;
  function [7:0] rnd(input [7:0] v);
    rnd = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task cmp(input string n, input [7:0] e, input [7:0] g);
    compares = compares + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(negedge sys_clk_i) {ptr_wr_i, ptr_i} = {1'b1, a};
    @(negedge sys_clk_i) {ptr_wr_i, data_wr_i, wdata_i} = {2'b01, d};
    @(negedge sys_clk_i) data_wr_i = 1'b0;
  endtask
  // Second byte of a pair keeps the pointer
  task rd(input [7:0] a, input c, input [7:0] e);
    if (!c)
      @(negedge sys_clk_i) {ptr_wr_i, ptr_i} = {1'b1, a};
    @(negedge sys_clk_i) {ptr_wr_i, rd_req_i, rd_cont_i} = {2'b01, c};
    expq.push_back(e);
    @(negedge sys_clk_i) {rd_req_i, rd_cont_i} = 2'b00;
  endtask
  task wb(input v);
    integer i;
    for (i = 0; i < 400 && conv_busy_o !== v; i = i + 1)
      @(negedge sys_clk_i);
    cmp("busy", {7'h00, v}, {7'h00, conv_busy_o});
  endtask
  // Counts falling edges that still see busy, from the current one
  task sl(input [7:0] e);
    integer n;
    n = 0;
    while (conv_busy_o === 1'b1 && n < 255) begin
      n = n + 1;
      @(negedge sys_clk_i);
    end
    cmp("busy_len", e, n[7:0]);
  endtask
  task test_done;
    if (bad_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(negedge sys_clk_i) begin
    if (rd_valid_o === 1'b1)
      cmp("rd_data", expq.size() ? expq.pop_front() : 8'hxx, rd_data_o);
  end
  initial begin
    #200000;
    bad_count = bad_count + 1;
    test_done;
  end
  initial begin
    repeat (8) @(negedge sys_clk_i);
    rst_i = 1'b0;
    rd(8'h00, 0, 8'h00);
    rd(8'h10, 0, 8'h00);
    rd(8'h08, 0, 8'h80);
    rd(8'h0a, 0, 8'h1c);
    rd(8'h09, 0, 8'h00);
    rd(8'h0b, 0, 8'h07);
    lfsr = rnd(lfsr);
    wr(8'h0b, lfsr & 8'h07);
    rd(8'h0b, 0, lfsr & 8'h07);
    wr(8'h0a, 8'h3c);
    rd(8'h0a, 0, 8'h3c);
    wr(8'h09, 8'h44);
    @(negedge sys_clk_i);
    cmp("range", 8'h01, {7'h00, ext_range_o});
    wb(0);
    repeat (300) @(negedge sys_clk_i);
    wb(0);
    lfsr = rnd(lfsr);
    wr(8'h0f, lfsr);
    wb(1);
    wr(8'h0f, lfsr);
    sl(8'd57);
    wb(0);
    s = seq;
    rd(8'h00, 0, {s, 2'h0});
    rd(8'h10, 0, {s, 2'h3});
    rd(8'h01, 0, {s, 2'h1});
    rd(8'h01, 1, {s, 2'h2});
    rd(8'h12, 0, {s, 2'h1});
    wr(8'h00, lfsr);
    rd(8'h00, 0, {s, 2'h0});
    rd(8'h0f, 0, 8'h00);
    wr(8'h0b, 8'h00);
    wr(8'h09, 8'h00);
    wb(1);
    sl(8'd60);
    wb(0);
    wr(8'h0a, 8'h38);
    cmp("rc", 8'h00, {7'h00, conv_rc_o});
    wr(8'h0f, 8'h00);
    wb(1);
    sl(8'd40);
    test_done;
  end
endmodule
`default_nettype wire
